// ==== design/sacs_pkg.sv ====
// Purpose: constants and types shared by the conversion sequencer
// Assumes: system clock of 125 MHz, conversion clock counted in ticks
// Notes:   all counts are in conversion-clock cycles unless named _clks

package sacs_pkg;

    // ************************************************************
    // conversion timing
    // ************************************************************
    localparam int unsigned ACQ_CCLKS   = 3;   // least acquisition time
    localparam int unsigned CONV_CCLKS  = 18;  // conversion length
    localparam int unsigned FAST_PERIOD = 21;  // auto trigger, rate bit 0
    localparam int unsigned SLOW_PERIOD = 42;  // auto trigger, rate bit 1
    localparam int unsigned FAST_GAP    = FAST_PERIOD - CONV_CCLKS;
    localparam int unsigned SLOW_GAP    = SLOW_PERIOD - CONV_CCLKS;

    // ************************************************************
    // internal oscillator model
    // ************************************************************
    localparam int unsigned CLK_FREQ_HZ = 125_000_000;
    localparam int unsigned OSC_FREQ_HZ = 12_500_000;
    localparam int unsigned OSC_DIV_CLKS = CLK_FREQ_HZ / OSC_FREQ_HZ;

    // ************************************************************
    // field encodings and reset values
    // ************************************************************
    localparam logic [1:0] STATUS_EOC   = 2'h3;
    localparam logic [1:0] STATUS_INT   = 2'h2;
    localparam logic       SRC_OSC      = 1'h0;
    localparam logic       SRC_SCLK     = 1'h1;
    localparam logic       TRIG_AUTO    = 1'h0;
    localparam logic       SEL_AUTO     = 1'h1;
    localparam logic [2:0] CHANNEL_RST  = 3'h0;
    localparam logic [5:0] CNT_RST      = 6'h00;
    localparam logic [3:0] DIV_RST      = 4'h0;

    // ************************************************************
    // sequencer states, one-hot
    // ************************************************************
    typedef enum logic [2:0] {
        SACS_IDLE = 3'b001,   // manual trigger, acquiring, waiting start
        SACS_ACQ  = 3'b010,   // auto trigger, timed acquisition
        SACS_CONV = 3'b100    // hold, conversion running
    } sacs_state_t;

endpackage

// ==== design/sacs_sequencer.sv ====
// Purpose: conversion clock, channel and trigger sequencing of a SAR
//          converter, plus the programmable status pin
// Assumes: config bits come from logic on i_clk; convert_start_n and
//          the serial clock come from pins
// Notes:   conversion clock is a one-cycle tick in the i_clk domain
//
// Operation
// - internal oscillator runs only while converting, unless auto trigger or nap
// - acquire at least three conversion clocks (manual trigger: no minimum, a start edge right after end converts at once); convert for eighteen
// - serial clock source: conversion clock toggles each rising serial edge
// - serial clock source, manual trigger: conversion ends after 36 serial clocks
// - manual selection: host writes channel number, acquisition uses it
// - automatic selection active after reset and while mode bit is one
// - auto selection starts at last channel, steps up, wraps to start
// - starting at the highest channel repeats that channel
// - sequencer stops stepping once mode bit is written to zero
// - manual trigger: start pin falling edge ends acquisition, starts conversion
// - start input acts independently of frame select
// - auto trigger, rate zero: next start three clocks after end
// - status field 11: pin marks end of conversion, asserted while converting
// - manual: pin asserts after start edge, holds, releases at end
// - auto, rate zero: pin stays released three conversion clocks between conversions
// - status field 10: interrupt set at end, cleared by next read
// - status pin polarity follows the polarity bit
// - auto trigger, slow rate: starts spaced 42 conversion clocks

`timescale 1ns/1ns

module sacs_sequencer
#(
    parameter int unsigned MAX_CHANNEL = 7
) (
    // system clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    // link side: serial clock and start pin
    input  wire logic       i_sclk,
    input  wire logic       i_convert_start_n,
    // configuration bits
    input  wire logic       i_clock_source,
    input  wire logic       i_channel_select_mode,
    input  wire logic       i_trigger_mode,
    input  wire logic       i_auto_rate,
    input  wire logic       i_auto_nap_en,
    input  wire logic [1:0] i_status_function,
    input  wire logic       i_status_polarity,
    // command port
    input  wire logic       i_cmd_channel_we,
    input  wire logic [2:0] i_cmd_channel,
    input  wire logic       i_read_done,
    // status and core control
    output logic            o_status,
    output logic            o_hold,
    output logic            o_conv_start,
    output logic            o_conv_done,
    output logic [2:0]      o_channel,
    output logic            o_osc_run
);
    import sacs_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    sacs_state_t state_ff, nxt_state;
    logic       sclk_rst1_ff, sclk_rst2_ff, sclk_toggle_ff;
    logic       tog_s1_ff, tog_s2_ff, tog_s3_ff;
    logic       cs_s1_ff, cs_s2_ff, cs_s3_ff;
    logic [3:0] div_ff;
    logic       tick_ff;
    logic [5:0] cnt_ff;
    logic       conv_end;
    logic       start_fall;
    logic [5:0] gap_len;
    logic [2:0] start_ch_ff;
    logic       mode_prev_ff;
    logic       int_flag_ff;
    logic       status_act;
    logic       status_ff, conv_start_ff, conv_done_ff, osc_run_ff;
    logic [2:0] channel_ff;

    // ************************************************************
    // link clock domain
    // ************************************************************
    // reset is brought into the serial domain; it only settles while
    // the serial clock runs, which is the only time the toggle matters
    always_ff @(posedge i_sclk) begin
        sclk_rst1_ff <= i_reset_n;
        sclk_rst2_ff <= sclk_rst1_ff;
    end
    // halving divider: one toggle per rising serial edge
    always_ff @(posedge i_sclk) begin
        if (!sclk_rst2_ff) begin
            sclk_toggle_ff <= 1'b0;
        end else begin
            sclk_toggle_ff <= ~sclk_toggle_ff;
        end
    end

    // ************************************************************
    // crossings into the system clock
    // ************************************************************
    // toggle level crosses by two flops; third flop feeds edge detect
    always_ff @(posedge i_clk) begin
        tog_s1_ff <= sclk_toggle_ff;
        tog_s2_ff <= tog_s1_ff;
        tog_s3_ff <= tog_s2_ff;
    end

    // start pin, resampled; frame select plays no part here
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            cs_s3_ff <= 1'b1;
        end else begin
            cs_s1_ff <= i_convert_start_n;
            cs_s2_ff <= cs_s1_ff;
            cs_s3_ff <= cs_s2_ff;
        end
    end
    assign start_fall = cs_s3_ff & ~cs_s2_ff;

    // ************************************************************
    // conversion clock
    // ************************************************************
    // oscillator gated off between manual conversions to save power
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            osc_run_ff <= 1'b0;
        end else begin
            osc_run_ff <= (nxt_state == SACS_CONV)
                        | (i_trigger_mode == TRIG_AUTO)
                        | i_auto_nap_en;
        end
    end

    // one tick per conversion clock; a full toggle period of the
    // serial divider is one conversion clock, i.e. two serial clocks
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            div_ff  <= DIV_RST;
            tick_ff <= 1'b0;
        end else if (i_clock_source == SRC_SCLK) begin
            div_ff  <= DIV_RST;
            tick_ff <= tog_s2_ff & ~tog_s3_ff;
        end else if (!osc_run_ff) begin
            div_ff  <= DIV_RST;
            tick_ff <= 1'b0;
        end else if (div_ff == 4'(OSC_DIV_CLKS - 1)) begin
            div_ff  <= DIV_RST;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 4'h1;
            tick_ff <= 1'b0;
        end
    end

    // ************************************************************
    // trigger sequencer
    // ************************************************************
    assign gap_len  = i_auto_rate ? 6'(SLOW_GAP) : 6'(FAST_GAP);
    assign conv_end = (state_ff == SACS_CONV) && tick_ff
                   && (cnt_ff == 6'(CONV_CCLKS - 1));

    // next state; a start edge during conversion is ignored
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SACS_IDLE: begin
                if (i_trigger_mode == TRIG_AUTO) begin
                    nxt_state = SACS_ACQ;
                end else if (start_fall) begin
                    nxt_state = SACS_CONV;
                end
            end
            SACS_ACQ: begin
                if (i_trigger_mode != TRIG_AUTO) begin
                    nxt_state = SACS_IDLE;
                end else if (tick_ff && cnt_ff == gap_len - 6'h1) begin
                    nxt_state = SACS_CONV;
                end
            end
            SACS_CONV: begin
                if (conv_end) begin
                    nxt_state = (i_trigger_mode == TRIG_AUTO)
                              ? SACS_ACQ : SACS_IDLE;
                end
            end
            default: nxt_state = SACS_IDLE;
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_ff <= SACS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end
    // conversion-clock counter, restarted on each state change
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || nxt_state != state_ff) begin
            cnt_ff <= CNT_RST;
        end else if (tick_ff) begin
            cnt_ff <= cnt_ff + 6'h1;
        end
    end
    // core strobes
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            conv_start_ff <= 1'b0;
            conv_done_ff  <= 1'b0;
        end else begin
            conv_start_ff <= (nxt_state == SACS_CONV)
                          && (state_ff != SACS_CONV);
            conv_done_ff  <= conv_end;
        end
    end

    // ************************************************************
    // channel selection
    // ************************************************************
    // auto selection holds after reset; entry remembers the start
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            mode_prev_ff <= SEL_AUTO;
            start_ch_ff  <= CHANNEL_RST;
        end else begin
            mode_prev_ff <= i_channel_select_mode;
            if (i_channel_select_mode && !mode_prev_ff) begin
                start_ch_ff <= channel_ff;
            end
        end
    end
    // the channel is not stepped in the cycle auto mode is entered,
    // so the first auto conversion uses the channel held on entry
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            channel_ff <= CHANNEL_RST;
        end else if (i_channel_select_mode != SEL_AUTO) begin
            if (i_cmd_channel_we) begin
                channel_ff <= i_cmd_channel;
            end
        end else if (conv_end && mode_prev_ff) begin
            if (channel_ff == 3'(MAX_CHANNEL)) begin
                channel_ff <= start_ch_ff;
            end else begin
                channel_ff <= channel_ff + 3'h1;
            end
        end
    end

    // ************************************************************
    // status pin
    // ************************************************************
    // interrupt flag: a new end of conversion wins over a read clear
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            int_flag_ff <= 1'b0;
        end else if (conv_end) begin
            int_flag_ff <= 1'b1;
        end else if (i_read_done) begin
            int_flag_ff <= 1'b0;
        end
    end
    always_comb begin
        status_act = 1'b0;
        if (i_status_function == STATUS_EOC) begin
            status_act = (nxt_state == SACS_CONV);
        end else if (i_status_function == STATUS_INT) begin
            status_act = int_flag_ff | conv_end;
        end
    end
    // polarity 1 means active high
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            status_ff <= 1'b1;
        end else begin
            status_ff <= i_status_polarity ? status_act
                                           : ~status_act;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_status     = status_ff;
    assign o_hold       = state_ff[2];
    assign o_conv_start = conv_start_ff;
    assign o_conv_done  = conv_done_ff;
    assign o_channel    = channel_ff;
    assign o_osc_run    = osc_run_ff;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // helper: conversion clocks seen in hold and in auto acquisition
    logic [5:0] chk_conv_ticks_ff, chk_acq_ticks_ff;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || state_ff != SACS_CONV) begin
            chk_conv_ticks_ff <= CNT_RST;
        end else if (tick_ff) begin
            chk_conv_ticks_ff <= chk_conv_ticks_ff + 6'h1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || state_ff != SACS_ACQ) begin
            chk_acq_ticks_ff <= CNT_RST;
        end else if (tick_ff) begin
            chk_acq_ticks_ff <= chk_acq_ticks_ff + 6'h1;
        end
    end
    chk_conv_length: assert property (
        $fell(o_hold) |-> $past(chk_conv_ticks_ff) == 6'd17 && o_conv_done)
        else $error("conversion did not last 18 conversion clocks");
    chk_fast_gap: assert property (
        (state_ff == SACS_ACQ && nxt_state == SACS_CONV && !i_auto_rate
         && $stable(i_auto_rate)) |-> chk_acq_ticks_ff == 6'd2)
        else $error("fast auto trigger gap is not 3 conversion clocks");
    chk_slow_gap: assert property (
        (state_ff == SACS_ACQ && nxt_state == SACS_CONV && i_auto_rate
         && $stable(i_auto_rate)) |-> chk_acq_ticks_ff == 6'd23)
        else $error("slow auto trigger gap is not 24 conversion clocks");
    chk_osc_gating: assert property (
        (!o_osc_run && i_clock_source == SRC_OSC
         && $stable(i_clock_source)) |=> !tick_ff)
        else $error("oscillator ticked while stopped");
    chk_manual_start: assert property (
        (state_ff == SACS_IDLE && i_trigger_mode != TRIG_AUTO
         && start_fall) |=> o_hold ##1 o_conv_start == 1'b0)
        else $error("start edge did not begin conversion");
    chk_eoc_level: assert property (
        (i_status_function == STATUS_EOC && !i_status_polarity
         && $stable(i_status_function) && $stable(i_status_polarity)
         && o_hold && $past(o_hold)) |-> !o_status)
        else $error("active low end of conversion not low in hold");
    chk_int_clear: assert property (
        (i_status_function == STATUS_INT && i_status_polarity
         && $stable(i_status_function) && i_read_done && !conv_end)
        ##1 (!conv_end && $stable(i_status_function)
             && $stable(i_status_polarity)) |=> !o_status)
        else $error("interrupt not cleared by read");
    chk_auto_wrap: assert property (
        (conv_end && i_channel_select_mode && mode_prev_ff
         && o_channel == 3'(MAX_CHANNEL)) |=> o_channel == $past(start_ch_ff))
        else $error("auto selection did not wrap to start channel");
    chk_manual_chan: assert property (
        (i_channel_select_mode != SEL_AUTO && i_cmd_channel_we)
        |=> o_channel == $past(i_cmd_channel))
        else $error("manual channel write not taken");
    cov_manual_conv: cover property (
        (state_ff == SACS_IDLE && start_fall) ##[1:1000] o_conv_done);
    cov_auto_wrap: cover property (
        conv_end && i_channel_select_mode && o_channel == 3'(MAX_CHANNEL));
    cov_int_clear: cover property (int_flag_ff && i_read_done);
    cov_sclk_conv: cover property (
        i_clock_source == SRC_SCLK && o_conv_done);

endmodule

// ==== test/sacs_host_model.sv ====
// Purpose: host side model, serial clock and start pin
// Assumes: the bench spaces its start requests
// Notes:   serial clock stands still unless asked to run
`timescale 1ns/1ns

module sacs_host_model (
    // bench control
    input  wire logic i_clk,
    input  wire logic i_sclk_run,
    input  wire logic i_start_req,
    // pins toward the converter
    output logic      o_sclk,
    output logic      o_convert_start_n
);
    // ************************************************************
    // serial clock, 160 ns, phase unrelated to i_clk
    // ************************************************************
    initial begin
        o_sclk = 1'b0;
        #37;
        forever begin
            #80;
            o_sclk = i_sclk_run ? ~o_sclk : 1'b0;
        end
    end

    // ************************************************************
    // start pin
    // ************************************************************
    // low for six cycles; no frame select exists to gate it
    initial o_convert_start_n = 1'b1;
    always @(posedge i_clk) begin
        if (i_start_req) begin
            #1 o_convert_start_n = 1'b0;
            repeat (6) @(posedge i_clk);
            #1 o_convert_start_n = 1'b1;
        end
    end
endmodule

// ==== test/tb_sar_adc_conversion_sequencer.sv ====
// Purpose: self-checking bench of the conversion sequencer
// Assumes: oscillator tick every OSC_DIV_CLKS cycles of i_clk
// Notes:   reset is stretched so the serial domain sees three rising edges
`timescale 1ns/1ns

`define CHECK(nm, exp, got) \
    begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module tb_sar_adc_conversion_sequencer;
    import sacs_pkg::*;
    localparam int LIM = 3000;
    localparam int RST_CYC = 65;
    logic       i_clk, i_reset_n, i_sclk, i_convert_start_n;
    logic       i_clock_source, i_channel_select_mode, i_trigger_mode;
    logic       i_auto_rate, i_auto_nap_en, i_status_polarity;
    logic [1:0] i_status_function;
    logic       i_cmd_channel_we, i_read_done;
    logic [2:0] i_cmd_channel;
    logic       o_status, o_hold, o_conv_start, o_conv_done, o_osc_run;
    logic [2:0] o_channel;
    logic       sclk_run, start_req;
    int         miscompares, comparisons;

    // ************************************************************
    // design, host model and clock
    // ************************************************************
    sacs_sequencer #(.MAX_CHANNEL(7)) i_sacs_sequencer (.*);
    sacs_host_model i_sacs_host_model (
        .i_clk             (i_clk),
        .i_sclk_run        (sclk_run),
        .i_start_req       (start_req),
        .o_sclk            (i_sclk),
        .o_convert_start_n (i_convert_start_n)
    );
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic final_report();
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask
    // a used-up bound counts as a mismatch and ends the run
    task automatic limit_check(input int n);
        if (n >= LIM) begin
            miscompares++;
            final_report();
        end
    endtask
    // bounded wait for the next conversion start pulse
    task automatic wait_start(output int n);
        n = 0;
        do begin
            tick();
            n++;
        end while (o_conv_start !== 1'b1 && n < LIM);
        if (n >= LIM) begin
            miscompares++;
            final_report();
        end
    endtask
    task automatic hold_len(output int n);
        n = 0;
        while (o_hold === 1'b1 && n < LIM) begin
            tick();
            n++;
        end
        limit_check(n);
    endtask
    // host spaces starts far beyond 21 conversion clocks
    task automatic start_conv();
        int n;
        start_req = 1'b1;
        tick();
        start_req = 1'b0;
        wait_start(n);
    endtask
    task automatic write_channel(input logic [2:0] ch);
        i_cmd_channel = ch;
        i_cmd_channel_we = 1'b1;
        tick();
        i_cmd_channel_we = 1'b0;
        `CHECK("cmd_channel", ch, o_channel)
    endtask
    // auto trigger run, four conversions with period and gap checked
    task automatic auto_run(input logic rate, input logic [2:0] first);
        int h, g, n, per;
        logic [2:0] ch;
        per = rate ? SLOW_PERIOD : FAST_PERIOD;
        ch = first;
        i_auto_rate = rate;
        i_channel_select_mode = SEL_AUTO;
        i_trigger_mode = TRIG_AUTO;
        wait_start(n);
        for (int i = 0; i < 4; i++) begin
            `CHECK("auto_channel", ch, o_channel)
            `CHECK("osc_auto", 1'b1, o_osc_run)
            hold_len(h);
            `CHECK("auto_hold", CONV_CCLKS * OSC_DIV_CLKS, h)
            g = 0;
            while (o_status === 1'b1 && g < LIM) begin
                tick();
                g++;
            end
            limit_check(g);
            `CHECK("auto_gap", (per - CONV_CCLKS) * OSC_DIV_CLKS, g)
            `CHECK("auto_period", per * OSC_DIV_CLKS, h + g)
            `CHECK("auto_start", 1'b1, o_conv_start)
            ch = (ch == 3'h7) ? first : ch + 3'h1;
        end
    endtask
    task automatic stop_auto();
        int n;
        i_trigger_mode = 1'b1;
        hold_len(n);
        repeat (40) tick();
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        `CHECK("rst_hold", 1'b0, o_hold)
        `CHECK("rst_channel", 3'h0, o_channel)
        `CHECK("rst_status", 1'b1, o_status)
        `CHECK("rst_osc", 1'b0, o_osc_run)
        i_auto_nap_en = 1'b1;
        repeat (2) tick();
        `CHECK("nap_osc", 1'b1, o_osc_run)
        i_auto_nap_en = 1'b0;
        repeat (2) tick();
    endtask
    // oscillator source, manual trigger, active low end of conversion
    task automatic t_manual_osc();
        int h;
        start_conv();
        `CHECK("eoc_low", 1'b0, o_status)
        `CHECK("hold_up", 1'b1, o_hold)
        `CHECK("osc_on", 1'b1, o_osc_run)
        hold_len(h);
        `CHECK("osc_hold", 1'b1, h >= 170 && h <= 192)
        `CHECK("conv_done", 1'b1, o_conv_done)
        `CHECK("eoc_high", 1'b1, o_status)
        repeat (3) tick();
        `CHECK("osc_off", 1'b0, o_osc_run)
        repeat (40) tick();
    endtask
    // interrupt use, active high, cleared by a read
    task automatic t_interrupt();
        int h;
        i_status_function = STATUS_INT;
        i_status_polarity = 1'b1;
        i_read_done = 1'b1;
        tick();
        i_read_done = 1'b0;
        tick();
        `CHECK("int_idle", 1'b0, o_status)
        start_conv();
        `CHECK("int_busy", 1'b0, o_status)
        hold_len(h);
        repeat (2) tick();
        `CHECK("int_set", 1'b1, o_status)
        repeat (5) tick();
        `CHECK("int_stays", 1'b1, o_status)
        i_read_done = 1'b1;
        tick();
        i_read_done = 1'b0;
        tick();
        `CHECK("int_clear", 1'b0, o_status)
        i_status_function = STATUS_EOC;
        i_status_polarity = 1'b0;
        repeat (40) tick();
    endtask
    // serial clock source: 36 serial periods of 20 cycles each
    task automatic t_serial();
        int h;
        i_clock_source = SRC_SCLK;
        sclk_run = 1'b1;
        repeat (10) tick();
        start_conv();
        hold_len(h);
        `CHECK("sclk_hold", 1'b1, h >= 676 && h <= 764)
        `CHECK("sclk_done", 1'b1, o_conv_done)
        repeat (100) tick();
        sclk_run = 1'b0;
        i_clock_source = SRC_OSC;
        repeat (40) tick();
    endtask
    // start at 5, step 6 7 then wrap; mode bit cleared stops stepping
    task automatic t_auto_fast();
        logic [2:0] ch;
        int h, n;
        write_channel(3'h5);
        auto_run(1'b0, 3'h5);
        // sequence 5 6 7 5 ran; the fifth conversion already uses 6
        ch = 3'h6;
        i_channel_select_mode = 1'b0;
        for (int i = 0; i < 2; i++) begin
            hold_len(h);
            wait_start(n);
            `CHECK("no_step", ch, o_channel)
        end
        stop_auto();
    endtask
    // start at the highest channel repeats it, slow rate
    task automatic t_auto_slow();
        write_channel(3'h7);
        auto_run(1'b1, 3'h7);
        i_channel_select_mode = 1'b0;
        stop_auto();
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        miscompares = 0;
        comparisons = 0;
        i_reset_n = 1'b0;
        i_clock_source = SRC_OSC;
        i_channel_select_mode = 1'b0;
        i_trigger_mode = 1'b1;
        i_auto_rate = 1'b0;
        i_auto_nap_en = 1'b0;
        i_status_function = STATUS_EOC;
        i_status_polarity = 1'b0;
        i_cmd_channel_we = 1'b0;
        i_cmd_channel = 3'h0;
        i_read_done = 1'b0;
        start_req = 1'b0;
        sclk_run = 1'b1;
        // serial divider is cleared only on the third serial rising edge
        repeat (RST_CYC) tick();
        i_reset_n = 1'b1;
        sclk_run = 1'b0;
        repeat (2) tick();
        t_reset();
        t_manual_osc();
        t_interrupt();
        t_serial();
        t_auto_fast();
        t_auto_slow();
        final_report();
    end
endmodule
